// *** verilog/rwseq_pkg.sv ***
// Shared constants and types for the reset and watchdog sequencer.
package rwseq_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned PIN_FILTER_NS = 1000;
  // Least time rounds up to whole cycles.
  localparam int unsigned PIN_FILTER_CYC = (PIN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RELEASE_CYC = 4096;
  localparam int unsigned OSC_SETTLE_CYC = 1024;
  localparam int unsigned WDOG_TIMEOUT_CYC = 65536;

  // ----------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [15:0] BOOT_ADDR = 16'h0000;
  localparam logic [1:0] HOST_SEL_UART = 2'h0;
  localparam logic [1:0] HOST_SEL_SPI = 2'h1;
  localparam logic [1:0] HOST_SEL_I2C = 2'h2;

  typedef enum logic [1:0] {
    RWSEQ_ST_HOLD,
    RWSEQ_ST_COUNT,
    RWSEQ_ST_RUN
  } rwseq_state_e;

endpackage

// *** verilog/rwseq_sync2.sv ***
// Two-flop synchroniser for one asynchronous level.
module rwseq_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic ref_clk, // System clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic din, // Asynchronous level.
  output logic dout // Synchronised level.
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic meta;
    logic sync;
  } rwseq_sync_s;

  rwseq_sync_s s_r;
  rwseq_sync_s s_nxt;

  // The first stage feeds only the second.
  always_comb begin
    s_nxt.meta = din;
    s_nxt.sync = s_r.meta;
  end

  // Both stages reset to the idle level.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= {RST_VAL, RST_VAL};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dout = s_r.sync;

endmodule

// *** verilog/rwseq_top.sv ***
// Reset sequencer combining supply monitor, watchdog and filtered pin.
//
// What this block does
// - Supply rising above threshold at power-up starts the reset sequence.
// - Supply dropping below operating level during operation asserts reset.
// - Watchdog counts only while the core runs; each firmware refresh restarts it.
// - Watchdog expiry without refresh starts a full system reset.
// - Pin low resets a running core only after one microsecond continuous; during the release count any low restarts it.
// - During reset all digital logic halts except clock management.
// - Reset holds until pin is high, then 4096 cycles pass.
// - On release the processor fetches from address zero.
// - Two config pins sampled at reset select exactly one host interface.
// - At reset, writable configuration reloads from saved nonvolatile values.
// - After reset run internal oscillator 1024 cycles, then external if present.
module rwseq_top
  import rwseq_pkg::*;
#(
  parameter int unsigned RELEASE_CYCLES = RELEASE_CYC, // Release timer length.
  parameter int unsigned WDOG_CYCLES = WDOG_TIMEOUT_CYC, // Watchdog timeout.
  parameter int unsigned FILTER_CYCLES = PIN_FILTER_CYC, // Pin low filter.
  parameter int unsigned SETTLE_CYCLES = OSC_SETTLE_CYC // Oscillator settle time.
) (
  input wire logic ref_clk, // Always running management clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic supply_ok, // Digital supply above minimum, async.
  input wire logic ext_rst_n, // External reset pin, active low, async.
  input wire logic wdog_refresh, // Firmware refresh pulse, same clock.
  input wire logic [1:0] host_sel_pins, // Shared interface select pins, async.
  input wire logic ext_clk_ok, // External oscillator present, async.
  output logic core_rst_n, // Digital core reset, active low.
  output logic [15:0] core_start_addr, // Fetch address at release.
  output logic uart_en, // UART host interface enabled.
  output logic spi_en, // SPI host interface enabled.
  output logic i2c_en, // I2C host interface enabled.
  output logic cfg_reload, // One-cycle pulse: reload config from flash.
  output logic clk_sel_ext, // High when external clock selected.
  output logic wdog_reset_flag // Last reset came from the watchdog.
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic supply_ok_s;
  logic ext_rst_n_s;
  logic ext_clk_ok_s;
  logic [1:0] host_sel_s;

  rwseq_sync2 #(.RST_VAL(1'b0)) u_sync_supply (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .din(supply_ok),
    .dout(supply_ok_s)
  );

  rwseq_sync2 #(.RST_VAL(1'b1)) u_sync_pin (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .din(ext_rst_n),
    .dout(ext_rst_n_s)
  );

  rwseq_sync2 #(.RST_VAL(1'b0)) u_sync_xclk (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .din(ext_clk_ok),
    .dout(ext_clk_ok_s)
  );

  rwseq_sync2 #(.RST_VAL(1'b0)) u_sync_sel0 (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .din(host_sel_pins[0]),
    .dout(host_sel_s[0])
  );

  rwseq_sync2 #(.RST_VAL(1'b0)) u_sync_sel1 (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .din(host_sel_pins[1]),
    .dout(host_sel_s[1])
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    rwseq_state_e state;
    logic [12:0] rel_cnt;
    logic [16:0] wdog_cnt;
    logic [7:0] filt_cnt;
    logic [10:0] osc_cnt;
    logic pin_rst;
    logic wdog_hit;
    logic core_rst_n;
    logic [15:0] start_addr;
    logic uart_en;
    logic spi_en;
    logic i2c_en;
    logic cfg_reload;
    logic clk_sel_ext;
    logic wdog_flag;
  } rwseq_regs_s;

  rwseq_regs_s r_r;
  rwseq_regs_s r_nxt;
  logic rst_req;

  localparam logic [12:0] REL_LAST = 13'(RELEASE_CYCLES - 1);
  localparam logic [16:0] WDOG_LAST = 17'(WDOG_CYCLES - 1);
  localparam logic [7:0] FILT_LAST = 8'(FILTER_CYCLES - 1);
  localparam logic [10:0] OSC_LAST = 11'(SETTLE_CYCLES - 1);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Every source feeds one request so each release follows the same timer.
  always_comb begin
    r_nxt = r_r;
    r_nxt.cfg_reload = 1'b0;
    r_nxt.wdog_hit = 1'b0;
    // Pin filter: count continuous low cycles; any high resets the count.
    if (ext_rst_n_s) begin
      r_nxt.filt_cnt = '0;
      r_nxt.pin_rst = 1'b0;
    end else if (r_r.filt_cnt == FILT_LAST) begin
      r_nxt.pin_rst = 1'b1;
    end else begin
      r_nxt.filt_cnt = r_r.filt_cnt + 8'h01;
    end
    // Watchdog runs only while the core runs; a refresh restarts it.
    if (r_r.state != RWSEQ_ST_RUN || wdog_refresh) begin
      r_nxt.wdog_cnt = '0;
    end else if (r_r.wdog_cnt == WDOG_LAST) begin
      r_nxt.wdog_hit = 1'b1;
      r_nxt.wdog_cnt = '0;
    end else begin
      r_nxt.wdog_cnt = r_r.wdog_cnt + 17'h00001;
    end
    rst_req = !supply_ok_s || r_r.pin_rst || r_r.wdog_hit;
    case (r_r.state)
      RWSEQ_ST_HOLD: begin
        // Core frozen; clock select forced to internal and settle count cleared.
        r_nxt.core_rst_n = 1'b0;
        r_nxt.rel_cnt = '0;
        r_nxt.osc_cnt = '0;
        r_nxt.clk_sel_ext = 1'b0;
        if (!rst_req && ext_rst_n_s) begin
          r_nxt.state = RWSEQ_ST_COUNT;
        end
      end
      RWSEQ_ST_COUNT: begin
        if (rst_req || !ext_rst_n_s) begin
          r_nxt.state = RWSEQ_ST_HOLD;
        end else if (r_r.rel_cnt == REL_LAST) begin
          r_nxt.state = RWSEQ_ST_RUN;
          r_nxt.core_rst_n = 1'b1;
          r_nxt.start_addr = BOOT_ADDR;
          r_nxt.cfg_reload = 1'b1;
          // Exactly one host interface is enabled per sample.
          r_nxt.uart_en = (host_sel_s == HOST_SEL_UART) || (host_sel_s == 2'h3);
          r_nxt.spi_en = (host_sel_s == HOST_SEL_SPI);
          r_nxt.i2c_en = (host_sel_s == HOST_SEL_I2C);
        end else begin
          r_nxt.rel_cnt = r_r.rel_cnt + 13'h0001;
        end
      end
      RWSEQ_ST_RUN: begin
        if (rst_req) begin
          r_nxt.state = RWSEQ_ST_HOLD;
          r_nxt.core_rst_n = 1'b0;
          r_nxt.clk_sel_ext = 1'b0;
          r_nxt.wdog_flag = r_r.wdog_hit;
        end else if (r_r.osc_cnt != OSC_LAST) begin
          r_nxt.osc_cnt = r_r.osc_cnt + 11'h001;
        end else begin
          // Falls back to internal if the external source disappears.
          r_nxt.clk_sel_ext = ext_clk_ok_s;
        end
      end
      default: begin
        r_nxt.state = RWSEQ_ST_HOLD;
      end
    endcase
  end

  // Power-up state holds the core in reset.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r_r <= '{state: RWSEQ_ST_HOLD, uart_en: 1'b1, default: '0};
    end else begin
      r_r <= r_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign core_rst_n = r_r.core_rst_n;
  assign core_start_addr = r_r.start_addr;
  assign uart_en = r_r.uart_en;
  assign spi_en = r_r.spi_en;
  assign i2c_en = r_r.i2c_en;
  assign cfg_reload = r_r.cfg_reload;
  assign clk_sel_ext = r_r.clk_sel_ext;
  assign wdog_reset_flag = r_r.wdog_flag;

endmodule

// *** sim/rwseq_top_properties.sv ***
// Concurrent checks on the ports of the reset sequencer.
module rwseq_top_checker #(
  parameter int unsigned RELEASE_CYCLES = 16 // Release timer length.
) (
  input wire logic ref_clk, // Clock.
  input wire logic nrst, // Reset, active low.
  input wire logic supply_ok, // Supply good.
  input wire logic core_rst_n, // Core reset.
  input wire logic [15:0] core_start_addr, // Fetch address.
  input wire logic uart_en, // UART enable.
  input wire logic spi_en, // SPI enable.
  input wire logic i2c_en, // I2C enable.
  input wire logic cfg_reload, // Reload pulse.
  input wire logic clk_sel_ext, // Clock select.
  input wire logic wdog_reset_flag // Watchdog cause.
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Helper logic and properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic [15:0] low_cnt_r;
  // Counts how long the core has been held; saturates so it never wraps.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) low_cnt_r <= 16'h0000;
    else if (core_rst_n) low_cnt_r <= 16'h0000;
    else if (low_cnt_r != 16'hffff) low_cnt_r <= low_cnt_r + 16'h0001;
  end
  sequence s_release;
    $rose(core_rst_n);
  endsequence
  property p_hold_len;
    s_release |-> low_cnt_r >= RELEASE_CYCLES;
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("core released early");
  property p_reload;
    cfg_reload |-> s_release;
  endproperty
  a_reload: assert property (p_reload) else $error("reload off release");
  property p_reload_once;
    cfg_reload |=> !cfg_reload;
  endproperty
  a_reload_once: assert property (p_reload_once) else $error("reload too long");
  property p_boot;
    s_release |-> core_start_addr == 16'h0000;
  endproperty
  a_boot: assert property (p_boot) else $error("boot address wrong");
  property p_onehot;
    $onehot({uart_en, spi_en, i2c_en});
  endproperty
  a_onehot: assert property (p_onehot) else $error("host enables not one-hot");
  property p_host_keep;
    core_rst_n && $past(core_rst_n) |-> $stable({uart_en, spi_en, i2c_en});
  endproperty
  a_host_keep: assert property (p_host_keep) else $error("host changed in run");
  property p_brown;
    !supply_ok |-> ##[0:5] !core_rst_n;
  endproperty
  a_brown: assert property (p_brown) else $error("no reset on low supply");
  property p_wdog;
    $rose(wdog_reset_flag) |-> ##[0:3] !core_rst_n;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog flag without reset");
  property p_osc;
    s_release |-> !clk_sel_ext [*8];
  endproperty
  a_osc: assert property (p_osc) else $error("external clock too soon");
endmodule
bind rwseq_top rwseq_top_checker #(.RELEASE_CYCLES(RELEASE_CYCLES)) u_chk (.ref_clk(ref_clk),
  .nrst(nrst), .supply_ok(supply_ok), .core_rst_n(core_rst_n),
  .core_start_addr(core_start_addr), .uart_en(uart_en), .spi_en(spi_en), .i2c_en(i2c_en),
  .cfg_reload(cfg_reload), .clk_sel_ext(clk_sel_ext), .wdog_reset_flag(wdog_reset_flag));

// *** sim/rwseq_board.sv ***
// Board reset driver model that pulls the reset pin low on command.
module rwseq_board (
  input wire logic ref_clk, // Clock for timing pulses.
  output logic ext_rst_n // Reset pin, pulled up when idle.
);
  timeunit 1ns;
  timeprecision 1ps;
  initial ext_rst_n = 1'b1;
  // Holds the pin low for n cycles; the pull-up returns it high after.
  task automatic pulse(input int n);
    @(negedge ref_clk) ext_rst_n = 1'b0;
    repeat (n) @(negedge ref_clk);
    ext_rst_n = 1'b1;
  endtask
endmodule

// *** sim/reset_watchdog_sequencer_test.sv ***
// Self-checking bench for the reset sequencer.
module reset_watchdog_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  import rwseq_pkg::*;
  localparam int RC = 16;
  logic ref_clk = 1'b0, nrst = 1'b0, supply_ok = 1'b1, wdog_refresh = 1'b0, ext_clk_ok = 1'b1;
  logic [1:0] host_sel_pins = 2'h0;
  logic ext_rst_n, core_rst_n, uart_en, spi_en, i2c_en, cfg_reload, clk_sel_ext, wdog_f;
  logic [15:0] core_start_addr;
  int error_cnt = 0, checks_done = 0, n;
  always #5 ref_clk = ~ref_clk;
  logic feed_on = 1'b1;
  logic [4:0] feed_cnt = 5'h00;
  // Firmware stand-in: refreshes every 32 cycles, well inside the 64-cycle watchdog.
  always @(negedge ref_clk) begin
    feed_cnt <= feed_cnt + 5'h01;
    wdog_refresh <= feed_on && (feed_cnt == 5'h1f);
  end
  rwseq_board board (.ref_clk(ref_clk), .ext_rst_n(ext_rst_n));
  rwseq_top #(.RELEASE_CYCLES(RC), .WDOG_CYCLES(64), .FILTER_CYCLES(100),
    .SETTLE_CYCLES(8)) dut (.ref_clk(ref_clk), .nrst(nrst), .supply_ok(supply_ok),
    .ext_rst_n(ext_rst_n), .wdog_refresh(wdog_refresh), .host_sel_pins(host_sel_pins),
    .ext_clk_ok(ext_clk_ok), .core_rst_n(core_rst_n), .core_start_addr(core_start_addr),
    .uart_en(uart_en), .spi_en(spi_en), .i2c_en(i2c_en), .cfg_reload(cfg_reload),
    .clk_sel_ext(clk_sel_ext), .wdog_reset_flag(wdog_f));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask
  // Waits for the core to leave reset, then checks the release side effects.
  task automatic wait_up();
    n = 0;
    while (core_rst_n !== 1'b1 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 400) begin
      chk("release_timeout", 16'h0001, 16'h0000);
      complete_run();
    end
    chk("hold_long_enough", 16'h0001, {15'h0, n >= RC});
    chk("reload_pulse", 16'h0001, {15'h0, cfg_reload});
    chk("boot_addr", BOOT_ADDR, core_start_addr);
    @(negedge ref_clk);
    chk("reload_end", 16'h0000, {15'h0, cfg_reload});
    chk("internal_osc", 16'h0000, {15'h0, clk_sel_ext});
    repeat (12) @(negedge ref_clk);
    chk("external_osc", 16'h0001, {15'h0, clk_sel_ext});
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_host();
    logic [2:0] exp;
    for (int c = 0; c < 4; c++) begin
      host_sel_pins = c[1:0];
      board.pulse(120);
      exp = (c == 1) ? 3'b010 : (c == 2) ? 3'b100 : 3'b001;
      wait_up();
      chk("host_enables", {13'h0, exp}, {13'h0, i2c_en, spi_en, uart_en});
    end
  endtask
  task automatic t_glitch();
    board.pulse(99);
    repeat (20) @(negedge ref_clk);
    chk("short_pulse_ignored", 16'h0001, {15'h0, core_rst_n});
  endtask
  // Fed watchdog must stay quiet; a starved one must reset within its window.
  task automatic t_wdog();
    repeat (200) @(negedge ref_clk);
    chk("refreshed_runs", 16'h0001, {15'h0, core_rst_n});
    chk("no_wdog_flag", 16'h0000, {15'h0, wdog_f});
    feed_on = 1'b0;
    n = 0;
    while (core_rst_n !== 1'b0 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    chk("wdog_reset", 16'h0000, {15'h0, core_rst_n});
    chk("wdog_not_early", 16'h0001, {15'h0, n >= 32});
    chk("wdog_flag", 16'h0001, {15'h0, wdog_f});
    if (n >= 100) begin
      complete_run();
    end
    feed_on = 1'b1;
    wait_up();
  endtask
  task automatic t_brown();
    supply_ok = 1'b0;
    repeat (40) @(negedge ref_clk);
    chk("brownout_hold", 16'h0000, {15'h0, core_rst_n});
    supply_ok = 1'b1;
    wait_up();
    chk("brownout_not_wdog", 16'h0000, {15'h0, wdog_f});
    ext_clk_ok = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk("osc_fallback", 16'h0000, {15'h0, clk_sel_ext});
    ext_clk_ok = 1'b1;
  endtask
  initial begin
    repeat (12) @(negedge ref_clk);
    nrst = 1'b1;
    wait_up();
    t_host();
    t_glitch();
    t_wdog();
    t_brown();
    complete_run();
  end
endmodule
